// [rtl/rxeq_params.svh]
// Offsets, field positions and reset values of the receive equalizer register bank
`ifndef RXEQ_PARAMS_SVH
`define RXEQ_PARAMS_SVH
`define RXEQ_OFS_STATUS 8'hD3
`define RXEQ_OFS_OVERRIDE 8'hD4
`define RXEQ_OFS_LIMITS 8'hD5
`define RXEQ_OFS_SKEW_CLK 8'hD6
`define RXEQ_OFS_SKEW_DAT 8'hD7
`define RXEQ_RST_OVERRIDE 8'h60
`define RXEQ_RST_LIMITS 8'hF2
`define RXEQ_RST_ZERO 8'h00
`define RXEQ_BYPASS_BIT 0
`define RXEQ_LOCKMODE_BIT 4
`define RXEQ_UPPER_HI 7
`define RXEQ_UPPER_LO 5
`define RXEQ_LOWER_HI 3
`define RXEQ_LOWER_LO 1
`define RXEQ_CEIL_HI 7
`define RXEQ_CEIL_LO 4
`define RXEQ_FLOOR_HI 3
`define RXEQ_FLOOR_LO 0
`define RXEQ_MAXED_BIT 7
`define RXEQ_SETTLED_BIT 6
`define RXEQ_FAULT_BIT 6
`define RXEQ_CODE_ZERO 6'h00
`define RXEQ_CODE_ONE 6'h01
`endif

// [rtl/rxeq_pkg.sv]
// Types shared by the receive equalizer register bank
`default_nettype none
package rxeq_pkg;
  typedef enum logic [2:0] {
    RXEQ_ST_START = 3'h1,
    RXEQ_ST_HUNT = 3'h2,
    RXEQ_ST_DONE = 3'h4
  } rxeq_state_t;
endpackage
`default_nettype wire

// [rtl/rxeq_adapt.sv]
// Adaptive equalizer search engine for one receive port
`timescale 1ns/1ns
`default_nettype none
`include "rxeq_params.svh"
module rxeq_adapt
  import rxeq_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic restart,
  input wire logic step,
  input wire logic lock_det,
  input wire logic floor_start_enable,
  input wire logic [3:0] eq_start_floor,
  input wire logic [3:0] eq_ceiling,
  output logic [5:0] code_q,
  output logic done_q
);
  rxeq_state_t state_q;
  logic [5:0] ceil_ext;
  logic [5:0] start_code;

  assign ceil_ext = {2'h0, eq_ceiling};
  assign start_code = floor_start_enable ? {2'h0, eq_start_floor} : `RXEQ_CODE_ZERO;

  // ----------------------------------------
  // Search state
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_q <= RXEQ_ST_START;
    end else if (restart) begin
      state_q <= RXEQ_ST_START;
    end else begin
      case (state_q)
        RXEQ_ST_START: state_q <= RXEQ_ST_HUNT;
        RXEQ_ST_HUNT: if (lock_det) state_q <= RXEQ_ST_DONE;
        RXEQ_ST_DONE: if (!lock_det) state_q <= RXEQ_ST_HUNT;
        default: state_q <= RXEQ_ST_START;
      endcase
    end
  end

  // ----------------------------------------
  // Setting: start point, then climb to the ceiling
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      code_q <= `RXEQ_CODE_ZERO;
    end else if (restart || state_q == RXEQ_ST_START) begin
      code_q <= (start_code > ceil_ext) ? ceil_ext : start_code;
    end else if (state_q == RXEQ_ST_HUNT && step && !lock_det && code_q < ceil_ext) begin
      code_q <= code_q + `RXEQ_CODE_ONE;
    end else if (code_q > ceil_ext) begin
      // Ceiling lowered by software under a running search
      code_q <= ceil_ext;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      done_q <= 1'b0;
    end else begin
      done_q <= (state_q == RXEQ_ST_DONE) && lock_det && !restart;
    end
  end
endmodule // rxeq_adapt
`default_nettype wire

// [rtl/rxeq_bank.sv]
// Per-port equalizer and skew filter register bank with readback
`timescale 1ns/1ns
`default_nettype none
`include "rxeq_params.svh"
module rxeq_bank
  import rxeq_pkg::*;
#(
  parameter int NPORTS = 4,
  parameter int PW = 2
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [PW-1:0] rx_port_idx,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata_q,
  input wire logic [NPORTS-1:0] lock_det_pin,
  input wire logic [NPORTS-1:0] eq_step,
  input wire logic [NPORTS-1:0] eq_restart,
  input wire logic [NPORTS-1:0] floor_start_enable,
  input wire logic [NPORTS-1:0] skew_limit_hit,
  input wire logic [NPORTS-1:0] skew_settled_now,
  input wire logic [NPORTS-1:0] skew_meas_bad,
  input wire logic [NPORTS*6-1:0] skew_clock_delay,
  input wire logic [NPORTS*6-1:0] skew_data_delay,
  output logic [NPORTS*6-1:0] eq_code_q,
  output logic [NPORTS-1:0] rx_lock_q
);
  logic [NPORTS-1:0] lock_meta_q;
  logic [NPORTS-1:0] lock_sync_q;
  logic [7:0] ovr_q [NPORTS];
  logic [7:0] lim_q [NPORTS];
  logic [5:0] acode [NPORTS];
  logic [NPORTS-1:0] adone;
  logic [NPORTS-1:0] maxed_q;
  logic [NPORTS-1:0] settled_q;
  logic [NPORTS-1:0] fault_q;
  logic [NPORTS-1:0] wr_hit;
  logic [NPORTS-1:0] rd_clk_hit;
  logic [NPORTS-1:0] rd_dat_hit;
  logic [7:0] rd_d;

  // ----------------------------------------
  // Lock detector crosses from the analog side
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      lock_meta_q <= '0;
      lock_sync_q <= '0;
    end else begin
      lock_meta_q <= lock_det_pin;
      lock_sync_q <= lock_meta_q;
    end
  end

  // ----------------------------------------
  // Per-port copies
  // ----------------------------------------
  for (genvar p = 0; p < NPORTS; p++) begin : g_port
    logic sel;
    logic bypass;
    logic [5:0] manual;
    assign sel = (rx_port_idx == PW'(p));
    assign wr_hit[p] = reg_wr && sel;
    assign rd_clk_hit[p] = reg_rd && sel && (reg_addr == `RXEQ_OFS_SKEW_CLK);
    assign rd_dat_hit[p] = reg_rd && sel && (reg_addr == `RXEQ_OFS_SKEW_DAT);
    assign bypass = ovr_q[p][`RXEQ_BYPASS_BIT];
    assign manual = {ovr_q[p][`RXEQ_UPPER_HI:`RXEQ_UPPER_LO],
                     ovr_q[p][`RXEQ_LOWER_HI:`RXEQ_LOWER_LO]};

    always_ff @(posedge core_clk) begin
      if (!rst_n) begin
        ovr_q[p] <= `RXEQ_RST_OVERRIDE;
      end else if (wr_hit[p] && reg_addr == `RXEQ_OFS_OVERRIDE) begin
        ovr_q[p] <= reg_wdata;
      end
    end

    always_ff @(posedge core_clk) begin
      if (!rst_n) begin
        lim_q[p] <= `RXEQ_RST_LIMITS;
      end else if (wr_hit[p] && reg_addr == `RXEQ_OFS_LIMITS) begin
        lim_q[p] <= reg_wdata;
      end
    end

    // Held in restart while bypassed so leaving bypass starts a fresh search
    rxeq_adapt u_adapt (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .restart(eq_restart[p] || bypass),
      .step(eq_step[p]),
      .lock_det(lock_sync_q[p]),
      .floor_start_enable(floor_start_enable[p]),
      .eq_start_floor(lim_q[p][`RXEQ_FLOOR_HI:`RXEQ_FLOOR_LO]),
      .eq_ceiling(lim_q[p][`RXEQ_CEIL_HI:`RXEQ_CEIL_LO]),
      .code_q(acode[p]),
      .done_q(adone[p])
    );

    always_ff @(posedge core_clk) begin
      if (!rst_n) begin
        eq_code_q[p*6 +: 6] <= `RXEQ_CODE_ZERO;
        rx_lock_q[p] <= 1'b0;
      end else begin
        eq_code_q[p*6 +: 6] <= bypass ? manual : acode[p];
        rx_lock_q[p] <= lock_sync_q[p] && (!ovr_q[p][`RXEQ_LOCKMODE_BIT] || bypass
                        || adone[p]);
      end
    end

    // For maxed_q and fault_q set wins over the clearing read; settled_q is latched by a read while skew_settled_now holds
    always_ff @(posedge core_clk) begin
      if (!rst_n) begin
        maxed_q[p] <= 1'b0;
        fault_q[p] <= 1'b0;
        settled_q[p] <= 1'b0;
      end else begin
        maxed_q[p] <= skew_limit_hit[p] || (maxed_q[p] && !rd_clk_hit[p]);
        fault_q[p] <= skew_meas_bad[p] || (fault_q[p] && !rd_dat_hit[p]);
        settled_q[p] <= skew_settled_now[p] && (settled_q[p] || rd_clk_hit[p]);
      end
    end
  end

  // ----------------------------------------
  // Readback of the selected port
  // ----------------------------------------
  always_comb begin
    rd_d = `RXEQ_RST_ZERO;
    if (reg_addr == `RXEQ_OFS_STATUS) begin
      rd_d = {2'h0, eq_code_q[rx_port_idx*6 +: 6]};
    end else if (reg_addr == `RXEQ_OFS_OVERRIDE) begin
      rd_d = ovr_q[rx_port_idx];
    end else if (reg_addr == `RXEQ_OFS_LIMITS) begin
      rd_d = lim_q[rx_port_idx];
    end else if (reg_addr == `RXEQ_OFS_SKEW_CLK) begin
      rd_d = {maxed_q[rx_port_idx], settled_q[rx_port_idx],
              skew_clock_delay[rx_port_idx*6 +: 6]};
    end else if (reg_addr == `RXEQ_OFS_SKEW_DAT) begin
      rd_d = {1'b0, fault_q[rx_port_idx], skew_data_delay[rx_port_idx*6 +: 6]};
    end
  end

  // Data is captured before the same read clears the sticky flags
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      reg_rdata_q <= `RXEQ_RST_ZERO;
    end else if (reg_rd) begin
      reg_rdata_q <= rd_d;
    end
  end

  // ----------------------------------------
  // Assertions on port 0
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_bypass_manual_code: assert property (ovr_q[0][`RXEQ_BYPASS_BIT] |=>
    eq_code_q[5:0] == {$past(ovr_q[0][7:5]), $past(ovr_q[0][3:1])}) else $error("bypass code");
  a_manual_bit_order: assert property (ovr_q[0] == 8'hA3 |=> eq_code_q[5:0] == 6'h29)
    else $error("manual order");
  a_lock_gated: assert property (rx_lock_q[0] && $past(ovr_q[0][4]) && !$past(ovr_q[0][0])
    |-> $past(adone[0])) else $error("lock before adaption");
  a_lock_follows: assert property (!ovr_q[0][4] |=> rx_lock_q[0] == $past(lock_sync_q[0]))
    else $error("lock mode 0");
  a_ceiling_held: assert property (##1 !$past(ovr_q[0][0]) && $stable(lim_q[0])
    |-> eq_code_q[5:0] <= {2'h0, $past(lim_q[0][7:4], 2)}) else $error("above ceiling");
  a_floor_start: assert property (eq_restart[0] && floor_start_enable[0] && !ovr_q[0][0]
    && lim_q[0][3:0] <= lim_q[0][7:4] && $stable(lim_q[0]) && !ovr_q[0][0]
    |=> acode[0] == {2'h0, $past(lim_q[0][3:0])}) else $error("floor start");
  a_status_read: assert property (reg_rd && reg_addr == `RXEQ_OFS_STATUS && rx_port_idx == '0
    |=> reg_rdata_q == {2'h0, $past(eq_code_q[5:0])}) else $error("status read");
  a_maxed_sticky: assert property (skew_limit_hit[0] ##1 !rd_clk_hit[0] [*2] |=> maxed_q[0])
    else $error("maxed lost");
  a_maxed_cleared: assert property (rd_clk_hit[0] && !skew_limit_hit[0] |=> !maxed_q[0])
    else $error("maxed not cleared");
  a_settled_latch: assert property (!skew_settled_now[0] ##1 !rd_clk_hit[0] |=> !settled_q[0])
    else $error("settled not latched");
  a_clock_delay: assert property (rd_clk_hit[0] |=> reg_rdata_q[5:0] ==
    $past(skew_clock_delay[5:0])) else $error("clock delay");
  a_fault_read: assert property (rd_dat_hit[0] && !skew_meas_bad[0] |=> !fault_q[0]
    && reg_rdata_q[6] == $past(fault_q[0])) else $error("fault read");
  a_data_delay: assert property (rd_dat_hit[0] |=> reg_rdata_q[5:0] ==
    $past(skew_data_delay[5:0]) && !reg_rdata_q[7]) else $error("data delay");
  a_port_isolate: assert property (reg_wr && rx_port_idx != '0 |=> $stable(ovr_q[0])
    && $stable(lim_q[0])) else $error("wrong port written");
  a_maxed_set: assert property (skew_limit_hit[0] |=> maxed_q[0])
    else $error("maxed not set");
  a_fault_set: assert property (skew_meas_bad[0] |=> fault_q[0])
    else $error("fault not set");
  a_settled_refresh: assert property (rd_clk_hit[0] |=>
    settled_q[0] == $past(skew_settled_now[0])) else $error("settled not refreshed");

  // ----------------------------------------
  // Coverage of the main scenarios
  // ----------------------------------------
  c_bypass_on: cover property (!ovr_q[0][0] ##1 ovr_q[0][0]);
  c_adapt_done: cover property (!adone[0] ##[1:50] adone[0]);
  c_maxed_read: cover property (maxed_q[0] && rd_clk_hit[0]);
  c_set_and_clear: cover property (skew_meas_bad[0] && rd_dat_hit[0]);
  c_lock_gated: cover property (ovr_q[0][4] && !ovr_q[0][0] && rx_lock_q[0]);
endmodule // rxeq_bank
`default_nettype wire

// [dv/rxeq_bank_tb.sv]
// Self-checking testbench for the receive equalizer register bank
`timescale 1ns/1ns
`default_nettype none
module rxeq_bank_tb;
  // ------------------------------------------------------------
  // Design and stimulus signals
  // ------------------------------------------------------------
  logic core_clk, rst_n, reg_wr, reg_rd;
  logic [1:0] rx_port_idx;
  logic [7:0] reg_addr, reg_wdata, reg_rdata_q;
  logic [7:0] ov [4];
  logic [7:0] lm [4];
  logic [3:0] lock_det_pin, eq_step, eq_restart, floor_start_enable, rx_lock_q;
  logic [3:0] skew_limit_hit, skew_settled_now, skew_meas_bad, c, f;
  logic [23:0] skew_clock_delay, skew_data_delay, eq_code_q;
  int fails, cmp_count;

  rxeq_bank rxeq_bank_i (
    .core_clk(core_clk), .rst_n(rst_n), .rx_port_idx(rx_port_idx),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_q(reg_rdata_q), .lock_det_pin(lock_det_pin), .eq_step(eq_step),
    .eq_restart(eq_restart), .floor_start_enable(floor_start_enable),
    .skew_limit_hit(skew_limit_hit), .skew_settled_now(skew_settled_now),
    .skew_meas_bad(skew_meas_bad), .skew_clock_delay(skew_clock_delay),
    .skew_data_delay(skew_data_delay), .eq_code_q(eq_code_q), .rx_lock_q(rx_lock_q)
  );

  always #4 core_clk = ~core_clk;

  // ------------------------------------------------------------
  // Bus tasks and comparisons
  // ------------------------------------------------------------
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", n, e, g);
      fails++;
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // One edge always passes with strobes low between two accesses
  task automatic acc(input int p, input logic [7:0] a, input logic [7:0] d, input logic w);
    tick(1);
    rx_port_idx = 2'(p);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = w;
    reg_rd = !w;
    tick(1);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  endtask

  task automatic rd(input int p, input logic [7:0] a, input logic [7:0] e, input string n);
    acc(p, a, 8'h00, 1'b0);
    chk(n, e, reg_rdata_q);
  endtask

  task automatic pulse(ref logic [3:0] s, input int p);
    s[p] = 1'b1;
    tick(1);
    s[p] = 1'b0;
    tick(2);
  endtask

  function automatic logic [7:0] man(input logic [7:0] v);
    return {2'b00, v[7:5], v[3:1]};
  endfunction

  function automatic logic [7:0] lo(input logic [3:0] a, input logic [3:0] b);
    return (a < b) ? {4'h0, a} : {4'h0, b};
  endfunction

  task automatic results;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(32'hB09925A1));
    core_clk = 1'b0;
    rst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    rx_port_idx = 2'h0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    {lock_det_pin, eq_step, eq_restart, floor_start_enable} = 16'h0000;
    {skew_limit_hit, skew_settled_now, skew_meas_bad} = 12'h000;
    skew_clock_delay = 24'($urandom);
    skew_data_delay = 24'($urandom);
    fails = 0;
    cmp_count = 0;
    tick(12);
    rst_n = 1'b1;
    for (int p = 0; p < 4; p++) begin
      rd(p, 8'hD3, 8'h00, "status reset");
      rd(p, 8'hD4, 8'h60, "override reset");
      rd(p, 8'hD5, 8'hF2, "limits reset");
      rd(p, 8'hD6, {2'b00, skew_clock_delay[p*6+:6]}, "clock delay");
      rd(p, 8'hD7, {2'b00, skew_data_delay[p*6+:6]}, "data delay");
      rd(p, 8'h10, 8'h00, "unmapped");
    end
    // Ports 2 and 3 always in bypass so both branches are seen
    for (int p = 0; p < 4; p++) begin
      ov[p] = 8'($urandom) | {7'h00, p > 1};
      lm[p] = 8'($urandom);
      acc(p, 8'hD4, ov[p], 1'b1);
      acc(p, 8'hD5, lm[p], 1'b1);
      acc(p, 8'hD3, 8'hFF, 1'b1);
    end
    for (int p = 0; p < 4; p++) begin
      rd(p, 8'hD4, ov[p], "override copy");
      rd(p, 8'hD5, lm[p], "limits copy");
      rd(p, 8'hD3, ov[p][0] ? man(ov[p]) : 8'h00, "status");
      chk("code", ov[p][0] ? man(ov[p]) : 8'h00, {2'b00, eq_code_q[p*6+:6]});
    end
    acc(0, 8'hD4, 8'h00, 1'b1);
    for (int i = 0; i < 5; i++) begin
      c = (i == 0) ? 4'h3 : 4'($urandom);
      f = (i == 0) ? 4'h9 : 4'($urandom);
      floor_start_enable[0] = (i != 3);
      acc(0, 8'hD5, {c, f}, 1'b1);
      pulse(eq_restart, 0);
      chk("start", (i != 3) ? lo(f, c) : 8'h00, {2'b00, eq_code_q[5:0]});
      repeat (18) pulse(eq_step, 0);
      chk("ceiling", {4'h0, c}, {2'b00, eq_code_q[5:0]});
    end
    // Port 0 again, so the bank's port 0 assertions see these scenarios
    acc(0, 8'hD4, 8'h00, 1'b1);
    lock_det_pin[0] = 1'b1;
    tick(2);
    chk("lock early", 8'h00, {7'h00, rx_lock_q[0]});
    tick(1);
    chk("lock direct", 8'h01, {7'h00, rx_lock_q[0]});
    lock_det_pin[0] = 1'b0;
    acc(0, 8'hD4, 8'h10, 1'b1);
    pulse(eq_restart, 0);
    lock_det_pin[0] = 1'b1;
    tick(3);
    chk("lock waits", 8'h00, {7'h00, rx_lock_q[0]});
    tick(3);
    chk("lock adapted", 8'h01, {7'h00, rx_lock_q[0]});
    acc(0, 8'hD4, 8'hA3, 1'b1);
    rd(0, 8'hD3, 8'h29, "manual order");
    chk("manual code", man(8'hA3), {2'b00, eq_code_q[5:0]});
    skew_settled_now = 4'hF;
    rd(0, 8'hD6, {2'b00, skew_clock_delay[5:0]}, "settled stale");
    rd(0, 8'hD6, {2'b01, skew_clock_delay[5:0]}, "settled");
    skew_settled_now[0] = 1'b0;
    tick(1);
    skew_settled_now[0] = 1'b1;
    skew_clock_delay = 24'($urandom);
    rd(0, 8'hD6, {2'b00, skew_clock_delay[5:0]}, "settled latched");
    rd(0, 8'hD6, {2'b01, skew_clock_delay[5:0]}, "settled again");
    pulse(skew_limit_hit, 0);
    rd(2, 8'hD6, {2'b00, skew_clock_delay[17:12]}, "limit other port");
    rd(0, 8'hD6, {2'b11, skew_clock_delay[5:0]}, "at limit");
    rd(0, 8'hD6, {2'b01, skew_clock_delay[5:0]}, "limit cleared");
    skew_data_delay = 24'($urandom);
    pulse(skew_meas_bad, 0);
    rd(3, 8'hD7, {2'b00, skew_data_delay[23:18]}, "fault other port");
    rd(0, 8'hD7, {2'b01, skew_data_delay[5:0]}, "fault");
    // Fault event in the cycle of the clearing read must survive it
    skew_meas_bad[0] = 1'b1;
    rd(0, 8'hD7, {2'b01, skew_data_delay[5:0]}, "fault set on read");
    skew_meas_bad[0] = 1'b0;
    rd(0, 8'hD7, {2'b01, skew_data_delay[5:0]}, "fault kept");
    rd(0, 8'hD7, {2'b00, skew_data_delay[5:0]}, "fault cleared");
    results();
  end

  initial begin
    #100000;
    fails++;
    results();
  end
endmodule // rxeq_bank_tb
`default_nettype wire
